// File: hw/scmd_core.sv
// serial eeprom command handling: spi slave, status bytes, page program and streamed reads
`timescale 1ns/10ps
`default_nettype none
`include "scmd_regs.svh"

// Contract
// (R01) opcode 04h clears the write enable latch.
// (R02) write disable ignores the write-protect pin.
// (R03) opcode 05h shifts out status byte 1 with busy and latch bits.
// (R04) opcode 01h updates only block-protect, auto powerdown, low-power standby, lock bits.
// (R05) lock bit cannot be cleared while write-protect is low.
// (R06) opcode 31h sets slow-oscillator and auto-deep-sleep bits; latch must be set.
// (R07) accepted byte-2 write raises busy; completion clears busy and latch.
// (R08) host sends read opcode then two address bytes, msb first.
// (R09) only fifteen low address bits decoded; host drives top bit zero.
// (R10) after read address, input ignored and data shifted out msb first.
// (R11) read address increments per byte and rolls over to zero.
// (R12) fast read 0Bh adds eight dummy bits; clock up to 10 MHz.
// (R13) host issues write enable in its own frame before program.
// (R14) internal write starts only on chip select rising after the frame.
// (R15) host raises chip select in clock low phase after last data bit.
// (R16) during internal write only status read is accepted.
// (R17) status bit 0 is one while writing, zero after.
// (R18) program increments only six low address bits, wrapping in the page.
// (R19) more than 64 bytes: last 64 are written.
// (R20) partial page writes only addressed bytes, others unchanged.
// (R21) program completion clears the write enable latch.
// (R22) program without latch is ignored until a new chip select frame.
// (R23) latch is zero at reset and set by opcode 06h.
// (R24) chip select rising mid-byte aborts; latch keeps its value.
// (R25) block-protect codes protect none, 6000-7FFF, 4000-7FFF, everything.
// (R26) input sampled on sck rising, output changed on sck falling.
module scmd_core
   import scmd_pkg::*;
#(
   parameter int unsigned PROG_TIME_NS = `SCMD_PROG_TIME_NS
) (
   input wire logic clk_i,                 // 100 MHz system clock
   input wire logic sys_rst_i,             // synchronous reset, active high
   input wire logic cs_n_i,                // chip select pin, active low
   input wire logic sck_i,                 // serial clock pin
   input wire logic sdi_i,                 // serial data in pin
   input wire logic wp_n_i,                // write-protect pin, active low
   output logic sdo_o,                     // serial data out
   output logic sdo_oe_o,                  // high while sdo is driven
   output logic [7:0] status1_o,           // status byte 1 as stored
   output logic slow_osc_o,                // slow oscillator bit
   output logic auto_deep_sleep_o          // auto deep sleep bit
);
   // =====================================================================
   // timing counts
   localparam int unsigned PROG_CYC = (PROG_TIME_NS + `SCMD_CLK_NS - 1) / `SCMD_CLK_NS;
   localparam int unsigned STAT_CYC = (`SCMD_STAT_TIME_NS + `SCMD_CLK_NS - 1) / `SCMD_CLK_NS;

   // =====================================================================
   // storage
   logic [7:0] mem [0:`SCMD_MEM_BYTES-1];
   logic [7:0] pbuf [0:`SCMD_PAGE_BYTES-1];
   logic [`SCMD_PAGE_BYTES-1:0] pmask;

   // =====================================================================
   // pin synchronisers, two flops each, sck and cs keep a third for edges
   logic [1:0] cs_sy, sck_sy, sdi_sy, wp_sy;
   logic cs_d, sck_d;
   always_ff @(posedge clk_i) begin
      cs_sy <= {cs_sy[0], cs_n_i};
      sck_sy <= {sck_sy[0], sck_i};
      sdi_sy <= {sdi_sy[0], sdi_i};
      wp_sy <= {wp_sy[0], wp_n_i};
      cs_d <= cs_sy[1];
      sck_d <= sck_sy[1];
   end

   wire logic cs_low = ~cs_sy[1];
   wire logic cs_fall = cs_d & ~cs_sy[1];
   wire logic cs_rise = ~cs_d & cs_sy[1];
   wire logic sck_rise = cs_low & ~sck_d & sck_sy[1];   // R26
   wire logic sck_fall = cs_low & sck_d & ~sck_sy[1];   // R26
   wire logic wp_low = ~wp_sy[1];

   // =====================================================================
   // state
   scmd_state_t state;
   scmd_pend_t pend;
   logic [2:0] bitcnt;
   logic [6:0] sh;
   logic [6:0] adhi;
   logic [`SCMD_ADDR_W-1:0] addr;
   logic [7:0] osh;
   logic wr_latch, busy, prot_lo, prot_hi, auto_pd, lp_stby, lock, slow, auds;
   logic [7:0] sr1_data, sr2_data;
   logic [31:0] timer;
   logic committing;
   logic [`SCMD_PAGE_W-1:0] cidx;
   logic [`SCMD_ADDR_W-`SCMD_PAGE_W-1:0] cpage;

   // protected if the address falls in the block chosen by the protect code
   function automatic logic is_protected(input logic [1:0] bp, input logic [`SCMD_ADDR_W-1:0] a);
      case (bp)
         2'b01: is_protected = (a >= `SCMD_BP_QUARTER);   // R25
         2'b10: is_protected = (a >= `SCMD_BP_HALF);   // R25
         2'b11: is_protected = 1'b1;   // R25
         default: is_protected = 1'b0;
      endcase
   endfunction : is_protected

   // =====================================================================
   // byte assembly and decode
   wire logic [7:0] in_byte = {sh, sdi_sy[1]};
   wire logic byte_done = sck_rise & (bitcnt == 3'h7);
   wire logic [`SCMD_ADDR_W-1:0] full_addr = {adhi[`SCMD_ADDR_W-9:0], in_byte};   // R09
   wire logic [`SCMD_ADDR_W-1:0] next_addr = addr + 15'h0001;   // R11
   wire logic [`SCMD_ADDR_W-1:0] next_waddr = {addr[`SCMD_ADDR_W-1:`SCMD_PAGE_W],
      addr[`SCMD_PAGE_W-1:0] + 6'h01};   // R18
   wire logic [7:0] status1 = {lock, 1'b0, lp_stby, auto_pd, prot_hi, prot_lo, wr_latch, busy};   // R03 R17
   wire logic whole_bytes = (bitcnt == 3'h0);   // R24
   wire logic is_read = (in_byte == `SCMD_OP_READ) | (in_byte == `SCMD_OP_FAST_READ);
   wire logic next_lock = (lock & wp_low) ? 1'b1 : sr1_data[`SCMD_SR_LOCK];   // R05

   // opcode decode: while busy everything but the status read is skipped
   scmd_state_t opc_next;
   always_comb begin
      opc_next = SCMD_SKIP;
      if (in_byte == `SCMD_OP_SR1_READ) begin
         opc_next = SCMD_STAT;   // R03
      end else if (busy) begin
         opc_next = SCMD_SKIP;   // R16
      end else if (is_read) begin
         opc_next = SCMD_ADHI;   // R08
      end else if (in_byte == `SCMD_OP_PROG) begin
         opc_next = wr_latch ? SCMD_ADHI : SCMD_SKIP;   // R22
      end else if (in_byte == `SCMD_OP_SR1_WRITE) begin
         opc_next = SCMD_SR1;
      end else if (in_byte == `SCMD_OP_SR2_WRITE) begin
         opc_next = SCMD_SR2;
      end
   end

   // =====================================================================
   // frame sequencer: bits in on sck rising, opcode and address phases
   logic is_prog, is_fast;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= SCMD_IDLE;
         pend <= SCMD_P_NONE;
         bitcnt <= 3'h0;
         sh <= 7'h00;
         adhi <= 7'h00;
         addr <= '0;
         osh <= 8'h00;
         is_prog <= 1'b0;
         is_fast <= 1'b0;
         sr1_data <= 8'h00;
         sr2_data <= 8'h00;
      end else if (cs_fall) begin
         state <= SCMD_OPC;
         pend <= SCMD_P_NONE;
         bitcnt <= 3'h0;
      end else if (!cs_low) begin
         state <= SCMD_IDLE;
      end else if (sck_rise) begin
         bitcnt <= bitcnt + 3'h1;
         sh <= in_byte[6:0];
         if (byte_done) begin
            case (state)
               SCMD_OPC: begin
                  state <= opc_next;
                  is_prog <= (in_byte == `SCMD_OP_PROG);
                  is_fast <= (in_byte == `SCMD_OP_FAST_READ);
                  if (!busy && in_byte == `SCMD_OP_WR_ENABLE) pend <= SCMD_P_WR_ENABLE;   // R23
                  if (!busy && in_byte == `SCMD_OP_WR_DISABLE) pend <= SCMD_P_WR_DISABLE;   // R01 R02
                  if (in_byte == `SCMD_OP_SR1_READ) osh <= status1;   // R03
               end
               SCMD_ADHI: begin
                  adhi <= in_byte[6:0];
                  state <= SCMD_ADLO;
               end
               SCMD_ADLO: begin
                  addr <= full_addr;
                  if (is_prog) begin
                     state <= is_protected({prot_hi, prot_lo}, full_addr) ? SCMD_SKIP : SCMD_WDATA;   // R25
                  end else if (is_fast) begin
                     state <= SCMD_DUMMY;   // R12
                  end else begin
                     state <= SCMD_RDATA;
                     osh <= mem[full_addr];   // R10
                     addr <= full_addr + 15'h0001;
                  end
               end
               SCMD_DUMMY: begin
                  state <= SCMD_RDATA;   // R12
                  osh <= mem[addr];
                  addr <= next_addr;
               end
               SCMD_RDATA: begin
                  osh <= mem[addr];   // R10 R11
                  addr <= next_addr;   // R11
               end
               SCMD_STAT: osh <= status1;
               SCMD_WDATA: begin
                  addr <= next_waddr;   // R18
                  pend <= SCMD_P_PROG;
               end
               SCMD_SR1: begin
                  sr1_data <= in_byte;
                  pend <= SCMD_P_SR1;
               end
               SCMD_SR2: begin
                  sr2_data <= in_byte;
                  pend <= SCMD_P_SR2;
               end
               default: state <= state;
            endcase
         end
      end else if (sck_fall) begin
         osh <= {osh[6:0], 1'b0};
      end
   end

   // =====================================================================
   // serial out: changes on sck falling, driven only in output phases
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sdo_o <= 1'b0;
         sdo_oe_o <= 1'b0;
      end else begin
         sdo_oe_o <= cs_low & ((state == SCMD_RDATA) | (state == SCMD_STAT));
         if (sck_fall) sdo_o <= osh[7];   // R26 R10
      end
   end

   // =====================================================================
   // page buffer: each frame begun while not busy starts clean so untouched bytes stay as they are;
   // later bytes to the same slot overwrite earlier ones
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pmask <= '0;
      end else if (cs_fall && !busy) begin
         pmask <= '0;   // R20
      end else if (byte_done && state == SCMD_WDATA) begin
         pmask[addr[`SCMD_PAGE_W-1:0]] <= 1'b1;   // R20
      end
   end

   always_ff @(posedge clk_i) begin
      if (byte_done && state == SCMD_WDATA) pbuf[addr[`SCMD_PAGE_W-1:0]] <= in_byte;   // R19
   end

   // array commit, one byte a cycle at the start of the write time;
   // no reset here since the contents are meant to survive it
   always_ff @(posedge clk_i) begin
      if (committing && pmask[cidx]) mem[{cpage, cidx}] <= pbuf[cidx];   // R20
   end

   // =====================================================================
   // latch, busy timer and stored status bits; commands act on chip select rising, timer expiry clears busy and latch
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wr_latch <= 1'b0;   // R23
         busy <= 1'b0;
         timer <= 32'h0;
         committing <= 1'b0;
         cidx <= '0;
         cpage <= '0;
         {prot_lo, prot_hi, auto_pd, lp_stby, lock, slow, auds} <= 7'h00;
      end else if (busy) begin
         timer <= timer - 32'h1;
         if (committing) begin
            cidx <= cidx + 6'h01;
            if (cidx == 6'h3f) committing <= 1'b0;
         end
         if (timer == 32'h1) begin
            busy <= 1'b0;   // R07 R17
            wr_latch <= 1'b0;   // R07 R21
         end
      end else if (cs_rise && whole_bytes) begin   // R24
         case (pend)
            SCMD_P_WR_ENABLE: wr_latch <= 1'b1;   // R23
            SCMD_P_WR_DISABLE: wr_latch <= 1'b0;   // R01 R02
            SCMD_P_PROG: begin
               busy <= 1'b1;   // R14
               timer <= PROG_CYC;
               committing <= 1'b1;
               cidx <= '0;
               cpage <= addr[`SCMD_ADDR_W-1:`SCMD_PAGE_W];
            end
            SCMD_P_SR1: if (wr_latch) begin
               prot_lo <= sr1_data[`SCMD_SR_PROT_LO];   // R04
               prot_hi <= sr1_data[`SCMD_SR_PROT_HI];   // R04
               auto_pd <= sr1_data[`SCMD_SR_AUTO_PD];   // R04
               lp_stby <= sr1_data[`SCMD_SR_LP_STBY];   // R04
               lock <= next_lock;   // R05
               busy <= 1'b1;
               timer <= STAT_CYC;
            end
            SCMD_P_SR2: if (wr_latch) begin
               slow <= sr2_data[`SCMD_SR2_SLOW];   // R06
               auds <= sr2_data[`SCMD_SR2_AUDS];   // R06
               busy <= 1'b1;   // R07
               timer <= STAT_CYC;
            end
            default: wr_latch <= wr_latch;
         endcase
      end
   end

   // =====================================================================
   // status outputs
   assign status1_o = status1;
   assign slow_osc_o = slow;
   assign auto_deep_sleep_o = auds;

endmodule : scmd_core
`default_nettype wire

// File: hw/scmd_regs.svh
// opcodes, status bit positions, array sizes and write timing for the serial command block
`ifndef SCMD_REGS_SVH
`define SCMD_REGS_SVH
// =====================================================================
// opcodes
`define SCMD_OP_SR1_WRITE 8'h01
`define SCMD_OP_PROG 8'h02
`define SCMD_OP_READ 8'h03
`define SCMD_OP_WR_DISABLE 8'h04
`define SCMD_OP_SR1_READ 8'h05
`define SCMD_OP_WR_ENABLE 8'h06
`define SCMD_OP_FAST_READ 8'h0b
`define SCMD_OP_SR2_WRITE 8'h31
// =====================================================================
// status byte 1 bit positions
`define SCMD_SR_BUSY 0
`define SCMD_SR_LATCH 1
`define SCMD_SR_PROT_LO 2
`define SCMD_SR_PROT_HI 3
`define SCMD_SR_AUTO_PD 4
`define SCMD_SR_LP_STBY 5
`define SCMD_SR_LOCK 7
// status byte 2 bit positions in the written data byte
`define SCMD_SR2_SLOW 0
`define SCMD_SR2_AUDS 1
// =====================================================================
// array geometry
`define SCMD_ADDR_W 15
`define SCMD_MEM_BYTES 32768
`define SCMD_PAGE_W 6
`define SCMD_PAGE_BYTES 64
// protected-area lower bounds for block-protect codes 01 and 10
`define SCMD_BP_QUARTER 15'h6000
`define SCMD_BP_HALF 15'h4000
// =====================================================================
// timing
`define SCMD_CLK_NS 10
`define SCMD_PROG_TIME_NS 3000000
`define SCMD_STAT_TIME_NS 10000
`endif

// File: hw/scmd_pkg.sv
// types shared by the serial command block
package scmd_pkg;
   // =====================================================================
   // frame phases
   typedef enum logic [3:0] {
      SCMD_IDLE, SCMD_OPC, SCMD_ADHI, SCMD_ADLO, SCMD_DUMMY,
      SCMD_RDATA, SCMD_STAT, SCMD_WDATA, SCMD_SR1, SCMD_SR2, SCMD_SKIP
   } scmd_state_t;
   // operation to carry out when chip select rises
   typedef enum logic [2:0] {
      SCMD_P_NONE, SCMD_P_WR_ENABLE, SCMD_P_WR_DISABLE, SCMD_P_PROG, SCMD_P_SR1, SCMD_P_SR2
   } scmd_pend_t;
endpackage : scmd_pkg

// File: sim/scmd_core_assertions.sv
// concurrent checks on the ports of the serial command block
`timescale 1ns/10ps
`default_nettype none
module scmd_core_assertions #(
   parameter int unsigned PROG_TIME_NS = 2000
) (
   input wire logic clk_i,               // system clock
   input wire logic sys_rst_i,           // synchronous reset
   input wire logic cs_n_i,              // chip select pin
   input wire logic sck_i,               // serial clock pin
   input wire logic sdi_i,               // serial data in
   input wire logic wp_n_i,              // write-protect pin
   input wire logic sdo_o,               // serial data out
   input wire logic sdo_oe_o,            // data out enable
   input wire logic [7:0] status1_o,     // status byte 1
   input wire logic slow_osc_o,          // slow oscillator bit
   input wire logic auto_deep_sleep_o    // auto deep sleep bit
);
   // =====================================================================
   // busy length counter: a stuck busy flag would hang every host
   localparam int BUSY_MAX = 1000 + PROG_TIME_NS / 10 + 8;
   int busy_cnt;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !status1_o[0]) busy_cnt <= 0;
      else busy_cnt <= busy_cnt + 1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // =====================================================================
   // properties
   a_oe_off_idle: assert property (cs_n_i [*5] |-> !sdo_oe_o)
      else $error("data out driven while deselected");
   a_sdo_after_fall: assert property (sdo_oe_o && $past(sdo_oe_o) && $changed(sdo_o)
      |-> !sck_i && !$past(sck_i, 3))
      else $error("data out changed outside clock low phase");
   a_spare_bit_zero: assert property (status1_o[6] == 1'b0)
      else $error("unused status bit set");
   a_wel_set_cause: assert property ($rose(status1_o[1]) |-> cs_n_i && !status1_o[0])
      else $error("latch set inside a frame or while busy");
   a_busy_at_cs_rise: assert property ($rose(status1_o[0]) |-> cs_n_i)
      else $error("internal write began inside a frame");
   a_busy_end_wel: assert property ($fell(status1_o[0]) |-> !status1_o[1])
      else $error("latch still set after write cycle");
   a_lock_needs_wp: assert property ($fell(status1_o[7]) |-> wp_n_i && $past(wp_n_i, 4))
      else $error("lock bit cleared with write-protect low");
   a_sr1_write_time: assert property ($changed(status1_o[7:2])
      |-> cs_n_i && (status1_o[0] || $past(status1_o[0])))
      else $error("protection bits changed outside a status write");
   a_sr2_write_time: assert property ($changed({slow_osc_o, auto_deep_sleep_o})
      |-> cs_n_i && (status1_o[0] || $past(status1_o[0])))
      else $error("byte 2 bits changed outside a status write");
   a_busy_bounded: assert property (busy_cnt <= BUSY_MAX)
      else $error("busy flag held too long");
   c_write_done: cover property ($fell(status1_o[0]));
   c_read_out: cover property (sdo_oe_o && !cs_n_i);
   c_slow_set: cover property ($rose(slow_osc_o));
endmodule : scmd_core_assertions
`default_nettype wire

// File: sim/scmd_host.sv
// spi host model that frames commands for the serial command block
`timescale 1ns/10ps
`default_nettype none
module scmd_host (
   input wire logic clk_i,   // pacing clock
   input wire logic sdo_i,   // data from the device
   output logic cs_n_o,      // chip select, active low
   output logic sck_o,       // serial clock, low between frames
   output logic sdi_o        // data to the device
);
   // =====================================================================
   // idle levels; clock stands still outside frames
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      sdi_o = 1'b0;
   end
   // all changes land 1 ns after a system clock edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick
   task automatic start();
      tick(1);
      cs_n_o = 1'b0;
      tick(5);
   endtask : start
   // half periods of 5 clk give a 10 MHz serial clock
   task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
      for (int i = 0; i < nb; i++) begin
         sdi_o = tx[7-i];
         tick(5);
         sck_o = 1'b1;
         rx[7-i] = sdo_i;
         tick(5);
         sck_o = 1'b0;
      end
   endtask : shift
   // deselect in the low phase after the last bit, then a long gap
   task automatic stop();
      tick(3);
      cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      tick(10);
   endtask : stop
endmodule : scmd_host
`default_nettype wire

// File: sim/scmd_core_tb.sv
// self-checking bench for the serial command block
`timescale 1ns/10ps
`default_nettype none
module scmd_core_tb;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic wp_n_i = 1'b1;
   logic cs_n, sck, sdi, sdo_o, sdo_oe_o, slow_osc_o, auto_deep_sleep_o;
   logic [7:0] status1_o;
   logic [7:0] q[$];
   logic [7:0] got[$];
   int fails = 0;
   int checked = 0;
   // rows: write-protect pin, opcode, expected status byte
   logic [16:0] rows[5] = '{17'h10602, 17'h10400, 17'h10602, 17'h00400, 17'h10602};
   always #5 clk_i = ~clk_i;
   scmd_core #(.PROG_TIME_NS(2000)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n),
      .sck_i(sck), .sdi_i(sdi), .wp_n_i(wp_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
      .status1_o(status1_o), .slow_osc_o(slow_osc_o), .auto_deep_sleep_o(auto_deep_sleep_o));
   // an undriven data line shows the inverse, so a read outside the output phase cannot pass
   wire logic sdo_line = sdo_oe_o ? sdo_o : ~sdo_o;
   scmd_host i_host (.clk_i(clk_i), .sdo_i(sdo_line), .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi));
   // =====================================================================
   // helpers
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic cmd(input logic [7:0] b[$], input int nb = 8);
      logic [7:0] r;
      i_host.start();
      foreach (b[k]) i_host.shift(b[k], (k == b.size() - 1) ? nb : 8, r);
      i_host.stop();
   endtask : cmd
   task automatic rd(input logic [7:0] b[$], input int n);
      logic [7:0] r;
      got = {};
      i_host.start();
      foreach (b[k]) i_host.shift(b[k], 8, r);
      repeat (n) begin
         i_host.shift(8'h00, 8, r);
         got.push_back(r);
      end
      i_host.stop();
   endtask : rd
   // bounded poll on the busy flag
   task automatic wait_idle();
      int n = 0;
      while (status1_o[0] !== 1'b0 && n < 3000) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n >= 3000) begin
         fails++;
         give_verdict();
      end
   endtask : wait_idle
   // =====================================================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      #1 sys_rst_i = 1'b0;
      check(status1_o, 8'h00);
      check({6'h00, slow_osc_o, sdo_oe_o}, 8'h00);
      repeat (4) @(posedge clk_i);
      #1;
      for (int k = 0; k < 5; k++) begin
         wp_n_i = rows[k][16];
         cmd({rows[k][15:8]});
         check(status1_o, rows[k][7:0]);
      end
      cmd({8'h04, 8'h00}, 3);
      check(status1_o, 8'h02);
      // program two bytes at the page end; the second wraps to the page start
      cmd({8'h02, 8'h7f, 8'hff, 8'ha1, 8'hb2});
      rd({8'h05}, 1);
      check(got[0], 8'h03);
      wait_idle();
      check(status1_o, 8'h00);
      cmd({8'h06});
      cmd({8'h02, 8'h00, 8'h00, 8'h5a});
      wait_idle();
      cmd({8'h02, 8'h00, 8'h00, 8'h11});
      check(status1_o, 8'h00);
      rd({8'h03, 8'h7f, 8'hff}, 2);
      check(got[0], 8'ha1);
      check(got[1], 8'h5a);
      rd({8'h0b, 8'h7f, 8'hc0, 8'h00}, 1);
      check(got[0], 8'hb2);
      // overlong page write: last 64 bytes win
      q = {8'h02, 8'h00, 8'h40};
      for (int i = 0; i < 66; i++) q.push_back(8'(i));
      cmd({8'h06});
      cmd(q);
      wait_idle();
      rd({8'h03, 8'h00, 8'h40}, 3);
      check(got[0], 8'h40);
      check(got[1], 8'h41);
      check(got[2], 8'h02);
      // status writes, protection and lock
      cmd({8'h06});
      cmd({8'h01, 8'hff});
      cmd({8'h04});
      check(status1_o, 8'hbf);
      wait_idle();
      check(status1_o, 8'hbc);
      cmd({8'h06});
      cmd({8'h02, 8'h00, 8'h00, 8'h77});
      wait_idle();
      rd({8'h03, 8'h00, 8'h00}, 1);
      check(got[0], 8'h5a);
      wp_n_i = 1'b0;
      cmd({8'h06});
      cmd({8'h01, 8'h00});
      wait_idle();
      check(status1_o, 8'h80);
      wp_n_i = 1'b1;
      cmd({8'h06});
      cmd({8'h01, 8'h00});
      wait_idle();
      check(status1_o, 8'h00);
      cmd({8'h06});
      cmd({8'h31, 8'h03});
      wait_idle();
      check({6'h00, slow_osc_o, auto_deep_sleep_o}, 8'h03);
      check(status1_o, 8'h00);
      sys_rst_i = 1'b1;
      repeat (8) @(posedge clk_i);
      #1 sys_rst_i = 1'b0;
      check({6'h00, slow_osc_o, auto_deep_sleep_o}, 8'h00);
      give_verdict();
   end
endmodule : scmd_core_tb
bind scmd_core scmd_core_assertions #(.PROG_TIME_NS(PROG_TIME_NS)) i_chk (.clk_i, .sys_rst_i, .cs_n_i,
   .sck_i, .sdi_i, .wp_n_i, .sdo_o, .sdo_oe_o, .status1_o, .slow_osc_o, .auto_deep_sleep_o);
`default_nettype wire
